// File: hw/adiag_regs.svh
// register offsets, error codes and timing counts of the diagnostic block
`ifndef ADIAG_REGS_SVH
`define ADIAG_REGS_SVH
`define ADIAG_OFS_RESET      16'h005A
`define ADIAG_OFS_FUNC       16'h005B
`define ADIAG_OFS_CODE       16'h005C
`define ADIAG_OFS_FAILREG    16'h005D
`define ADIAG_OFS_LASTWR     16'h005E
`define ADIAG_OFS_LASTRD     16'h005F
`define ADIAG_EXC_DETAIL     8'h04
`define ADIAG_ERR_NONE       8'h00
`define ADIAG_ERR_LIMIT      8'h02
`define ADIAG_ERR_SUBIDX     8'h03
`define ADIAG_ERR_TYPE       8'h05
`define ADIAG_ERR_GENERAL    8'h65
`define ADIAG_ERR_TIMEOUT    8'h66
`define ADIAG_ERR_RDONLY     8'h70
`define ADIAG_ERR_GROUPEND   8'h71
`define ADIAG_ERR_MSBNZ      8'h72
`define ADIAG_ERR_LSBONLY    8'h73
`define ADIAG_ERR_MSBONLY    8'h74
`define ADIAG_P32_BASE       17'd20000
`define ADIAG_P32_GROUP      17'd200
`define ADIAG_BLINK_MS       250
`define ADIAG_FLASH_MS       50
`define ADIAG_CLK_KHZ        10000
`define ADIAG_BLINK_CYC      (`ADIAG_BLINK_MS * `ADIAG_CLK_KHZ)
`define ADIAG_FLASH_CYC      (`ADIAG_FLASH_MS * `ADIAG_CLK_KHZ)
`endif

// File: hw/adiag_pkg.sv
// types of the diagnostic block
package adiag_pkg;
	typedef enum logic [1:0] {ADIAG_OFF = 2'b00, ADIAG_GREEN = 2'b01, ADIAG_RED = 2'b10, ADIAG_ORANGE = 2'b11} adiag_color_t;
	typedef enum logic [2:0] {
		HL_SETUP = 3'b000, HL_OK = 3'b001, HL_LOST = 3'b011, HL_FSERR = 3'b010
	} adiag_host_t;
	typedef enum logic [2:0] {
		PS_DHCP = 3'b000, PS_DAD = 3'b001, PS_IDLE = 3'b011, PS_ACTIVE = 3'b010,
		PS_LINKDN = 3'b110, PS_DISABLED = 3'b111
	} adiag_proto_t;
	// query completion report from the protocol engine
	typedef struct packed {
		logic        done;
		logic        ok;
		logic        is_write;
		logic [7:0]  exc_code;
		logic [7:0]  int_code;
		logic [7:0]  func_code;
		logic [15:0] reg_num;
	} adiag_query_t;
	// register access from the client side
	typedef struct packed {
		logic        wr;
		logic [15:0] addr;
		logic [15:0] wdata;
	} adiag_acc_t;
endpackage

// File: hw/adiag_top.sv
// diagnostic indicators and internal error registers of the adapter
`timescale 1ns/1ps
`include "adiag_regs.svh"
module adiag_top
	import adiag_pkg::*;
(
	// clock and reset
	input  wire logic         CLK,
	input  wire logic         RST,
	// host drive link state
	input  wire logic         HOST_UP,
	input  wire logic         HOST_LOST,
	input  wire logic         FS_ERROR,
	// network state
	input  wire logic         DHCP_BUSY,
	input  wire logic         DAD_BUSY,
	input  wire logic         IF_DISABLED,
	input  wire logic         LINK_UP,
	input  wire logic         LINK_100M,
	input  wire logic         LINK_ACTIVITY,
	input  wire logic         REQ_RECENT,
	// query report and register access
	input  wire adiag_query_t QUERY,
	input  wire adiag_acc_t   ACC,
	output logic [15:0]       RDATA,
	output logic              ADDR_HIT,
	// indicators
	output adiag_color_t      HOST_LED,
	output adiag_color_t      MODULE_LED,
	output adiag_color_t      SPEED_LED
);
	// two-flop synchronisers for pin-level status inputs
	logic [9:0] sync1_reg;
	logic [9:0] sync2_reg;
	always_ff @(posedge CLK) begin
		if (RST) begin
			sync1_reg <= 10'h000;
			sync2_reg <= 10'h000;
		end else begin
			sync1_reg <= {HOST_UP, HOST_LOST, FS_ERROR, DHCP_BUSY, DAD_BUSY, IF_DISABLED,
				LINK_UP, LINK_100M, LINK_ACTIVITY, REQ_RECENT};
			sync2_reg <= sync1_reg;
		end
	end
	wire s_host_up  = sync2_reg[9];
	wire s_host_lost = sync2_reg[8];
	wire s_fs_err   = sync2_reg[7];
	wire s_dhcp     = sync2_reg[6];
	wire s_dad      = sync2_reg[5];
	wire s_disabled = sync2_reg[4];
	wire s_link     = sync2_reg[3];
	wire s_100m     = sync2_reg[2];
	wire s_act      = sync2_reg[1];
	wire s_recent   = sync2_reg[0];

	// blink and flash phase generators
	logic [31:0] blink_cnt_reg;
	logic [31:0] flash_cnt_reg;
	logic        blink_reg;
	logic        flash_reg;
	wire         blink_wrap = (blink_cnt_reg == 32'(`ADIAG_BLINK_CYC - 1));
	wire         flash_wrap = (flash_cnt_reg == 32'(`ADIAG_FLASH_CYC - 1));
	always_ff @(posedge CLK) begin
		if (RST) begin
			blink_cnt_reg <= 32'h0;
			flash_cnt_reg <= 32'h0;
			blink_reg     <= 1'b0;
			flash_reg     <= 1'b0;
		end else begin
			blink_cnt_reg <= blink_wrap ? 32'h0 : blink_cnt_reg + 32'h1;
			flash_cnt_reg <= flash_wrap ? 32'h0 : flash_cnt_reg + 32'h1;
			if (blink_wrap) blink_reg <= ~blink_reg;
			if (flash_wrap) flash_reg <= ~flash_reg;
		end
	end

	// host-link state selection
	adiag_host_t host_next;
	assign host_next = s_fs_err ? HL_FSERR : s_host_lost ? HL_LOST : s_host_up ? HL_OK : HL_SETUP;

	// protocol state selection, priority from fault to normal
	adiag_proto_t proto_next;
	assign proto_next = s_disabled ? PS_DISABLED :
		!s_link ? PS_LINKDN :
		s_dad ? PS_DAD :
		s_dhcp ? PS_DHCP :
		s_recent ? PS_ACTIVE : PS_IDLE;

	adiag_host_t  host_reg;
	adiag_proto_t proto_reg;
	always_ff @(posedge CLK) begin
		if (RST) begin
			host_reg  <= HL_SETUP;
			proto_reg <= PS_IDLE;
		end else begin
			host_reg  <= host_next;
			proto_reg <= proto_next;
		end
	end

	// indicator colour decode
	adiag_color_t host_col;
	adiag_color_t mod_col;
	adiag_color_t spd_col;
	always_comb begin
		case (host_reg)
			HL_SETUP: host_col = blink_reg ? ADIAG_GREEN : ADIAG_OFF;
			HL_OK:    host_col = ADIAG_GREEN;
			HL_LOST:  host_col = blink_reg ? ADIAG_RED : ADIAG_OFF;
			HL_FSERR: host_col = blink_reg ? ADIAG_ORANGE : ADIAG_OFF;
			default:  host_col = ADIAG_OFF;
		endcase
		if (host_reg == HL_FSERR) begin
			mod_col = blink_reg ? ADIAG_OFF : ADIAG_ORANGE;
		end else begin
			case (proto_reg)
				PS_DHCP:     mod_col = flash_reg ? ADIAG_ORANGE : ADIAG_OFF;
				PS_DAD:      mod_col = ADIAG_ORANGE;
				PS_IDLE:     mod_col = flash_reg ? ADIAG_GREEN : ADIAG_OFF;
				PS_ACTIVE:   mod_col = ADIAG_GREEN;
				PS_LINKDN:   mod_col = flash_reg ? ADIAG_RED : ADIAG_OFF;
				PS_DISABLED: mod_col = ADIAG_RED;
				default:     mod_col = ADIAG_OFF;
			endcase
		end
		if (!s_link) begin
			spd_col = ADIAG_OFF;
		end else if (s_act && flash_reg) begin
			spd_col = ADIAG_OFF;
		end else begin
			spd_col = s_100m ? ADIAG_GREEN : ADIAG_ORANGE;
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			HOST_LED   <= ADIAG_OFF;
			MODULE_LED <= ADIAG_OFF;
			SPEED_LED  <= ADIAG_OFF;
		end else begin
			HOST_LED   <= host_col;
			MODULE_LED <= mod_col;
			SPEED_LED  <= spd_col;
		end
	end

	// error register bank
	logic [15:0] func_reg;
	logic [15:0] code_reg;
	logic [15:0] failreg_reg;
	logic [15:0] lastwr_reg;
	logic [15:0] lastrd_reg;

	// internal code is passed through as reported (0x02..0x74 set)
	wire q_fail   = QUERY.done && !QUERY.ok && (QUERY.exc_code == `ADIAG_EXC_DETAIL);
	wire q_ok     = QUERY.done && QUERY.ok;
	wire sw_reset = ACC.wr && (ACC.addr == `ADIAG_OFS_RESET) && ACC.wdata[0];
	wire [15:0] fail_code = {8'h00, QUERY.int_code};

	always_ff @(posedge CLK) begin
		if (RST) begin
			func_reg    <= 16'h0000;
			code_reg    <= 16'h0000;
			failreg_reg <= 16'h0000;
		end else if (q_fail) begin
			func_reg    <= {8'h00, QUERY.func_code};
			code_reg    <= fail_code;
			failreg_reg <= QUERY.reg_num;
		end else if (q_ok || sw_reset) begin
			func_reg    <= 16'h0000;
			code_reg    <= {8'h00, `ADIAG_ERR_NONE};
			failreg_reg <= 16'h0000;
		end
	end

	// last successful write and read register numbers
	always_ff @(posedge CLK) begin
		if (RST) begin
			lastwr_reg <= 16'h0000;
			lastrd_reg <= 16'h0000;
		end else if (q_ok) begin
			if (QUERY.is_write) lastwr_reg <= QUERY.reg_num;
			else lastrd_reg <= QUERY.reg_num;
		end else if (sw_reset) begin
			lastwr_reg <= 16'h0000;
			lastrd_reg <= 16'h0000;
		end
	end

	// read decode; 32-bit parameter addresses lie at 20000+200g+2i outside this bank
	always_comb begin
		ADDR_HIT = 1'b1;
		case (ACC.addr)
			`ADIAG_OFS_RESET:   RDATA = 16'h0000;
			`ADIAG_OFS_FUNC:    RDATA = func_reg;
			`ADIAG_OFS_CODE:    RDATA = code_reg;
			`ADIAG_OFS_FAILREG: RDATA = failreg_reg;
			`ADIAG_OFS_LASTWR:  RDATA = lastwr_reg;
			`ADIAG_OFS_LASTRD:  RDATA = lastrd_reg;
			default: begin
				RDATA    = 16'h0000;
				ADDR_HIT = 1'b0;
			end
		endcase
	end

	// checks
	a_fail_capture: assert property (@(posedge CLK) disable iff (RST)
		q_fail |=> code_reg == $past(fail_code) && failreg_reg == $past(QUERY.reg_num))
		else $error("error capture missed");
	a_ok_clears: assert property (@(posedge CLK) disable iff (RST)
		(q_ok && !q_fail) |=> code_reg == 16'h0000 && func_reg == 16'h0000)
		else $error("success did not clear");
	a_reset_clears: assert property (@(posedge CLK) disable iff (RST)
		(sw_reset && !q_fail && !q_ok) |=> lastwr_reg == 16'h0000 && lastrd_reg == 16'h0000)
		else $error("reset command did not clear");
	a_zero_ignored: assert property (@(posedge CLK) disable iff (RST)
		(ACC.wr && ACC.addr == `ADIAG_OFS_RESET && !ACC.wdata[0] && !QUERY.done) |=> $stable(code_reg))
		else $error("zero write changed registers");
	a_last_write: assert property (@(posedge CLK) disable iff (RST)
		(q_ok && QUERY.is_write) |=> lastwr_reg == $past(QUERY.reg_num) && $stable(lastrd_reg))
		else $error("last write not recorded");
	a_host_ok: assert property (@(posedge CLK) disable iff (RST)
		host_reg == HL_OK |=> HOST_LED == ADIAG_GREEN)
		else $error("host ok not steady green");
	a_fs_alternate: assert property (@(posedge CLK) disable iff (RST)
		host_reg == HL_FSERR |=> HOST_LED != MODULE_LED)
		else $error("file error not alternating");
	a_link_dark: assert property (@(posedge CLK) disable iff (RST)
		!s_link |=> SPEED_LED == ADIAG_OFF)
		else $error("speed lit with link down");
	a_disabled_red: assert property (@(posedge CLK) disable iff (RST)
		(proto_reg == PS_DISABLED && host_reg != HL_FSERR) |=> MODULE_LED == ADIAG_RED)
		else $error("disabled not steady red");
	a_dad_orange: assert property (@(posedge CLK) disable iff (RST)
		(proto_reg == PS_DAD && host_reg != HL_FSERR) |=> MODULE_LED == ADIAG_ORANGE)
		else $error("dad not steady orange");

	// host indicator phases follow the slow blink
	a_setup_blink: assert property (@(posedge CLK) disable iff (RST)
		host_reg == HL_SETUP |=> HOST_LED == ($past(blink_reg) ? ADIAG_GREEN : ADIAG_OFF))
		else $error("setup not blinking green");

	a_lost_blink: assert property (@(posedge CLK) disable iff (RST)
		host_reg == HL_LOST |=> HOST_LED == ($past(blink_reg) ? ADIAG_RED : ADIAG_OFF))
		else $error("lost not blinking red");

	a_fs_host_phase: assert property (@(posedge CLK) disable iff (RST)
		host_reg == HL_FSERR |=> HOST_LED == ($past(blink_reg) ? ADIAG_ORANGE : ADIAG_OFF))
		else $error("file error host phase wrong");

	a_fs_mod_phase: assert property (@(posedge CLK) disable iff (RST)
		host_reg == HL_FSERR |=> MODULE_LED == ($past(blink_reg) ? ADIAG_OFF : ADIAG_ORANGE))
		else $error("file error module phase wrong");

	a_fs_priority: assert property (@(posedge CLK) disable iff (RST)
		s_fs_err |=> host_reg == HL_FSERR)
		else $error("file error not taking priority");

	// protocol indicator phases follow the fast flash
	a_dhcp_flash: assert property (@(posedge CLK) disable iff (RST)
		(proto_reg == PS_DHCP && host_reg != HL_FSERR)
		|=> MODULE_LED == ($past(flash_reg) ? ADIAG_ORANGE : ADIAG_OFF))
		else $error("dhcp not flashing orange");

	a_idle_flash: assert property (@(posedge CLK) disable iff (RST)
		(proto_reg == PS_IDLE && host_reg != HL_FSERR)
		|=> MODULE_LED == ($past(flash_reg) ? ADIAG_GREEN : ADIAG_OFF))
		else $error("idle not flashing green");

	a_active_green: assert property (@(posedge CLK) disable iff (RST)
		(proto_reg == PS_ACTIVE && host_reg != HL_FSERR) |=> MODULE_LED == ADIAG_GREEN)
		else $error("active not steady green");

	a_linkdn_flash: assert property (@(posedge CLK) disable iff (RST)
		(proto_reg == PS_LINKDN && host_reg != HL_FSERR)
		|=> MODULE_LED == ($past(flash_reg) ? ADIAG_RED : ADIAG_OFF))
		else $error("link down not flashing red");

	a_disabled_prio: assert property (@(posedge CLK) disable iff (RST)
		s_disabled |=> proto_reg == PS_DISABLED)
		else $error("disabled not taking priority");

	// speed indicator colour and activity blanking
	a_speed_fast: assert property (@(posedge CLK) disable iff (RST)
		(s_link && s_100m && !(s_act && flash_reg)) |=> SPEED_LED == ADIAG_GREEN)
		else $error("fast link not green");

	a_speed_slow: assert property (@(posedge CLK) disable iff (RST)
		(s_link && !s_100m && !(s_act && flash_reg)) |=> SPEED_LED == ADIAG_ORANGE)
		else $error("slow link not orange");

	a_speed_blank: assert property (@(posedge CLK) disable iff (RST)
		(s_link && s_act && flash_reg) |=> SPEED_LED == ADIAG_OFF)
		else $error("activity did not blank speed");

	// phase counters stay inside their periods
	a_blink_bound: assert property (@(posedge CLK) disable iff (RST)
		blink_cnt_reg < 32'(`ADIAG_BLINK_CYC))
		else $error("blink counter out of range");

	a_flash_bound: assert property (@(posedge CLK) disable iff (RST)
		flash_cnt_reg < 32'(`ADIAG_FLASH_CYC))
		else $error("flash counter out of range");

	// error bank capture, refusal and clearing
	a_func_capture: assert property (@(posedge CLK) disable iff (RST)
		q_fail |=> func_reg == {8'h00, $past(QUERY.func_code)})
		else $error("function code not captured");

	a_exc_refused: assert property (@(posedge CLK) disable iff (RST)
		(QUERY.done && !QUERY.ok && QUERY.exc_code != `ADIAG_EXC_DETAIL && !sw_reset)
		|=> $stable(code_reg) && $stable(func_reg) && $stable(failreg_reg))
		else $error("other exception changed registers");

	a_code_upper: assert property (@(posedge CLK) disable iff (RST)
		code_reg[15:8] == 8'h00)
		else $error("error code upper byte set");

	a_reset_fields: assert property (@(posedge CLK) disable iff (RST)
		(sw_reset && !q_fail) |=> func_reg == 16'h0000 && code_reg == 16'h0000 && failreg_reg == 16'h0000)
		else $error("reset command left failure fields");

	a_ro_ignored: assert property (@(posedge CLK) disable iff (RST)
		(ACC.wr && ADDR_HIT && ACC.addr != `ADIAG_OFS_RESET && !QUERY.done)
		|=> $stable(func_reg) && $stable(code_reg) && $stable(lastwr_reg))
		else $error("read-only write changed registers");

	a_last_read: assert property (@(posedge CLK) disable iff (RST)
		(q_ok && !QUERY.is_write) |=> lastrd_reg == $past(QUERY.reg_num) && $stable(lastwr_reg))
		else $error("last read not recorded");

	a_hit_map: assert property (@(posedge CLK) disable iff (RST)
		ADDR_HIT == (ACC.addr >= `ADIAG_OFS_RESET && ACC.addr <= `ADIAG_OFS_LASTRD))
		else $error("address hit decode wrong");
endmodule

// File: tb/adiag_client.sv
// register client model on the network side of the diagnostic block
`timescale 1ns/1ps
module adiag_client
	import adiag_pkg::*;
(
	// clock
	input  wire logic        clk,
	// register access
	output adiag_acc_t       acc,
	input  wire logic [15:0] rdata,
	input  wire logic        hit
);
	// idle bus: no write strobe
	initial acc = '0;
	// one-cycle write strobe launched at the falling edge
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk);
		acc = '{1'b1, a, d};
		@(negedge clk);
		acc.wr = 1'b0;
		acc.wdata = ~d; // stale data is not left on the bus
	endtask
	// read data is combinational, sampled well before the next rising edge
	task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic h);
		@(negedge clk);
		acc.addr = a;
		#10;
		d = rdata;
		h = hit;
	endtask
endmodule

// File: tb/adiag_top_tb_top.sv
// self-checking bench of the diagnostic indicators and error registers
`timescale 1ns/1ps
module adiag_top_tb_top;
	import adiag_pkg::*;
	logic         clk;
	logic         rst;
	logic [9:0]   st; // up lost fs dhcp dad dis link 100m act recent
	adiag_query_t qry_r;
	adiag_acc_t   acc;
	logic [15:0]  rdata;
	logic         hit;
	adiag_color_t host_led, mod_led, spd_led;
	int           fail_count, tests_run, cyc;
	logic [15:0]  d;
	logic         h;
	logic [7:0]   codes [10] = '{8'h02, 8'h03, 8'h05, 8'h65, 8'h66, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74};
	// design and client
	adiag_top i_dut (.CLK(clk), .RST(rst), .HOST_UP(st[9]), .HOST_LOST(st[8]), .FS_ERROR(st[7]),
		.DHCP_BUSY(st[6]), .DAD_BUSY(st[5]), .IF_DISABLED(st[4]), .LINK_UP(st[3]), .LINK_100M(st[2]),
		.LINK_ACTIVITY(st[1]), .REQ_RECENT(st[0]), .QUERY(qry_r), .ACC(acc), .RDATA(rdata),
		.ADDR_HIT(hit), .HOST_LED(host_led), .MODULE_LED(mod_led), .SPEED_LED(spd_led));
	adiag_client i_client (.clk(clk), .acc(acc), .rdata(rdata), .hit(hit));
	// clock and hang limit
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	// compare helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [15:0] a, input logic [15:0] exp);
		i_client.rd(a, d, h);
		chk(d, exp);
		chk({15'h0, h}, 16'h0001);
	endtask
	task automatic one_of(input adiag_color_t got, input adiag_color_t a, input adiag_color_t b);
		chk({14'h0, got}, (got === b) ? {14'h0, b} : {14'h0, a});
	endtask
	// status levels, then settle through sync and indicator stages
	task automatic stat(input logic [9:0] v, input adiag_color_t h1, h2, m1, m2, s1, s2);
		@(negedge clk);
		st = v;
		repeat (6) @(negedge clk);
		one_of(host_led, h1, h2);
		one_of(mod_led, m1, m2);
		one_of(spd_led, s1, s2);
	endtask
	// one query completion report
	task automatic qry(input logic ok, w, input logic [7:0] e, i, f, input logic [15:0] r);
		@(negedge clk);
		qry_r = '{1'b1, ok, w, e, i, f, r};
		@(negedge clk);
		qry_r.done = 1'b0;
	endtask
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		rst = 1'b1;
		st = '0;
		qry_r = '0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		stat(10'b0000000000, ADIAG_GREEN, ADIAG_OFF, ADIAG_RED, ADIAG_OFF, ADIAG_OFF, ADIAG_OFF);
		stat(10'b1000101100, ADIAG_GREEN, ADIAG_GREEN, ADIAG_ORANGE, ADIAG_ORANGE, ADIAG_GREEN, ADIAG_GREEN);
		stat(10'b0101001000, ADIAG_RED, ADIAG_OFF, ADIAG_ORANGE, ADIAG_OFF, ADIAG_ORANGE, ADIAG_ORANGE);
		stat(10'b1000001001, ADIAG_GREEN, ADIAG_GREEN, ADIAG_GREEN, ADIAG_GREEN, ADIAG_ORANGE, ADIAG_ORANGE);
		stat(10'b1000001000, ADIAG_GREEN, ADIAG_GREEN, ADIAG_GREEN, ADIAG_OFF, ADIAG_ORANGE, ADIAG_ORANGE);
		stat(10'b1000011000, ADIAG_GREEN, ADIAG_GREEN, ADIAG_RED, ADIAG_RED, ADIAG_ORANGE, ADIAG_ORANGE);
		stat(10'b0010000000, ADIAG_ORANGE, ADIAG_OFF, ADIAG_ORANGE, ADIAG_OFF, ADIAG_OFF, ADIAG_OFF);
		chk({14'h0, host_led ^ mod_led}, 16'h0003);
		// reset values and an unmapped place
		for (int a = 16'h5A; a <= 16'h5F; a++) rdchk(16'(a), 16'h0000);
		i_client.rd(16'h0060, d, h);
		chk(d, 16'h0000);
		chk({15'h0, h}, 16'h0000);
		// every internal error code captured under the detail exception
		for (int k = 0; k < 10; k++) begin
			qry(1'b0, 1'b1, 8'h04, codes[k], 8'(16 + k), 16'(20000 + 200 * k + 2));
			rdchk(16'h005B, 16'(16 + k));
			rdchk(16'h005C, {8'h00, codes[k]});
			rdchk(16'h005D, 16'(20000 + 200 * k + 2));
		end
		qry(1'b0, 1'b0, 8'h02, 8'h65, 8'h06, 16'h0007);
		rdchk(16'h005C, 16'h0074);
		// two successes one idle cycle apart clear the failure and log good accesses
		qry(1'b1, 1'b1, 8'h00, 8'h00, 8'h06, 16'd300);
		qry(1'b1, 1'b0, 8'h00, 8'h00, 8'h03, 16'd318);
		for (int a = 16'h5B; a <= 16'h5D; a++) rdchk(16'(a), 16'h0000);
		rdchk(16'h005E, 16'd300);
		rdchk(16'h005F, 16'd318);
		// reset command: read-only write and zero ignored, one clears
		qry(1'b0, 1'b0, 8'h04, 8'h66, 8'h03, 16'd100);
		i_client.wr(16'h005B, 16'hFFFF);
		i_client.wr(16'h005A, 16'h0000);
		rdchk(16'h005B, 16'h0003);
		rdchk(16'h005C, 16'h0066);
		i_client.wr(16'h005A, 16'h0001);
		for (int a = 16'h5A; a <= 16'h5F; a++) rdchk(16'(a), 16'h0000);
		tally_and_finish();
	end
endmodule
